//--- pcg_core.sv
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module pcg_core #(
    parameter int LOCK_WINDOW = 16
)(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic oscillator_enable_from_sysint,
    input wire logic crystal_amp_input,
    output logic crystal_amp_output,
    output logic crystal_clock,
    output logic pll_reference_clock,
    output logic base_clock_out,
    output logic [15:0] filter_cap_node,
    output logic lock_change_req,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    logic [2:0] xsync;
    logic xlevel;
    logic xtal_tick;
    pcg_pkg::pcg_ctrl_t ctrl;
    pcg_pkg::pcg_bw_t bw;
    logic [7:0] prog;
    logic lock;
    logic pll_run;
    logic [15:0] nco;
    logic [16:0] nco_sum;
    logic vco_tick;
    logic fb_tick;
    logic pd_up;
    logic pd_dn;
    logic signed [16:0] trim;
    logic [16:0] rate;
    logic [7:0] win_cnt;
    logic [7:0] fb_cnt;
    logic [7:0] freq_err;
    logic win_end;
    pcg_pkg::pcg_sel_state_t sel_state;
    logic src_vco;
    logic target_vco;
    logic [1:0] hold_x;
    logic [1:0] hold_v;
    logic wr_ctrl;
    pcg_pkg::pcg_ctrl_t wctrl;

    // crystal pin: three stages, a change counts once stages two and three agree
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            xsync <= 3'h0;
            xlevel <= 1'b0;
        end
        else
        begin
            xsync <= {xsync[1:0], crystal_amp_input};
            if (xsync[1] == xsync[2])
                xlevel <= xsync[2];
        end
    end

    assign xtal_tick = oscillator_enable_from_sysint && xsync[1] == xsync[2]
        && xsync[2] && !xlevel;

    // amplifier and crystal clock outputs, dark while the oscillator is off
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            crystal_amp_output <= 1'b0;
            crystal_clock <= 1'b0;
            pll_reference_clock <= 1'b0;
        end
        else
        begin
            crystal_amp_output <= oscillator_enable_from_sysint
                && !xlevel;
            crystal_clock <= oscillator_enable_from_sysint && xlevel;
            pll_reference_clock <= crystal_clock;
        end
    end

    // range factor zero keeps the whole loop idle
    assign pll_run = ctrl.pll_on && prog[3:0] != 4'h0;

    // control register; pll and source may not change in one write
    assign wr_ctrl = reg_wr && reg_addr == pcg_pkg::ADDR_CTRL;
    assign wctrl = {reg_wdata[pcg_pkg::CTRL_IRQ_EN_BIT],
        reg_wdata[pcg_pkg::CTRL_PLL_ON_BIT], reg_wdata[pcg_pkg::CTRL_BCS_BIT]};
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctrl <= '0;
        end
        else if (wr_ctrl)
        begin
            ctrl.irq_en <= wctrl.irq_en;
            // pll can only be stopped while the crystal is selected
            if (wctrl.bcs == ctrl.bcs && (wctrl.pll_on || !ctrl.bcs))
                ctrl.pll_on <= wctrl.pll_on;
            // vco selectable only with the pll already on and L nonzero
            if (wctrl.pll_on == ctrl.pll_on
                && (!wctrl.bcs || pll_run))
                ctrl.bcs <= wctrl.bcs;
        end
        else if (!pll_run)
        begin
            ctrl.bcs <= 1'b0;
        end
    end

    // programming register: N high nibble, L low nibble
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            prog <= pcg_pkg::PROG_RESET;
        else if (reg_wr && reg_addr == pcg_pkg::ADDR_PROG)
            prog <= reg_wdata;
    end

    // numerically controlled vco: centre is L times the nominal base step
    assign rate = (trim + $signed({1'b0, 16'(prog[3:0]
        * pcg_pkg::VCO_NOM_INC)})) < 0 ? 17'h0 :
        17'(trim + $signed({1'b0, 16'(prog[3:0]
        * pcg_pkg::VCO_NOM_INC)}));
    assign nco_sum = {1'b0, nco} + {1'b0, rate[15:0]};
    always_ff @(posedge clk_sys)
    begin
        if (rst || !pll_run)
        begin
            nco <= 16'h0;
            vco_tick <= 1'b0;
        end
        else
        begin
            nco <= nco_sum[15:0];
            vco_tick <= nco_sum[16] || rate[16];
        end
    end

    pcg_mod_div #(.WIDTH(4)) u_fb_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick_in(vco_tick),
        .factor(prog[7:4]),
        .tick_out(fb_tick)
    );

    // phase detector: reference edge first means up, feedback first down
    always_ff @(posedge clk_sys)
    begin
        if (rst || !pll_run)
        begin
            pd_up <= 1'b0;
            pd_dn <= 1'b0;
        end
        else if ((pd_up || xtal_tick) && (pd_dn || fb_tick))
        begin
            pd_up <= 1'b0;
            pd_dn <= 1'b0;
        end
        else
        begin
            pd_up <= pd_up || xtal_tick;
            pd_dn <= pd_dn || fb_tick;
        end
    end

    // loop filter: width of the pulse sets the step count, mode the size
    always_ff @(posedge clk_sys)
    begin
        if (rst || !pll_run)
            trim <= 17'sh0;
        else if (pd_up)
            trim <= trim + $signed({1'b0, bw.track ? pcg_pkg::TRK_GAIN
                : pcg_pkg::PULL_GAIN});
        else if (pd_dn)
            trim <= trim - $signed({1'b0, bw.track ? pcg_pkg::TRK_GAIN
                : pcg_pkg::PULL_GAIN});
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            filter_cap_node <= 16'h0;
        else
            filter_cap_node <= rate[15:0];
    end

    // lock detector paced by reference edges
    assign win_end = xtal_tick && win_cnt == 8'(LOCK_WINDOW - 1);
    assign freq_err = fb_cnt > 8'(LOCK_WINDOW) ? fb_cnt - 8'(LOCK_WINDOW)
        : 8'(LOCK_WINDOW) - fb_cnt;
    always_ff @(posedge clk_sys)
    begin
        if (rst || !pll_run)
        begin
            win_cnt <= 8'h0;
            fb_cnt <= 8'h0;
        end
        else
        begin
            if (xtal_tick)
                win_cnt <= win_end ? 8'h0 : win_cnt + 8'h1;
            if (win_end)
                fb_cnt <= {7'h0, fb_tick};
            else if (fb_tick && fb_cnt != 8'hff)
                fb_cnt <= fb_cnt + 8'h1;
        end
    end

    // filter mode: detector in automatic mode, software in manual mode
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            bw <= '0;
        end
        else
        begin
            if (reg_wr && reg_addr == pcg_pkg::ADDR_BW)
                bw.auto_bw <= reg_wdata[pcg_pkg::BW_AUTO_BIT];
            if (!pll_run)
                bw.track <= 1'b0;
            else if (bw.auto_bw)
            begin
                if (win_end && freq_err <= pcg_pkg::TRK_TOL)
                    bw.track <= 1'b1;
                else if (win_end && freq_err > pcg_pkg::UNT_TOL)
                    bw.track <= 1'b0;
            end
            else if (reg_wr && reg_addr == pcg_pkg::ADDR_BW)
                bw.track <= reg_wdata[pcg_pkg::BW_TRACK_BIT];
        end
    end

    // lock flag with hysteresis; a change at a window end raises a one-cycle request when irq_en is set
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            lock <= 1'b0;
            lock_change_req <= 1'b0;
        end
        else
        begin
            lock_change_req <= 1'b0;
            if (!pll_run || !bw.auto_bw)
                lock <= 1'b0; // manual mode disables lock reporting
            else if (win_end && !lock && freq_err <= pcg_pkg::LOCK_TOL)
            begin
                lock <= 1'b1;
                lock_change_req <= ctrl.irq_en;
            end
            else if (win_end && lock && freq_err > pcg_pkg::UNL_TOL)
            begin
                lock <= 1'b0;
                lock_change_req <= ctrl.irq_en;
            end
        end
    end

    // base clock selector with glitch-free hold on switch-over
    assign target_vco = ctrl.bcs && pll_run;
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sel_state <= pcg_pkg::SEL_RUN;
            src_vco <= 1'b0;
            hold_x <= 2'h0;
            hold_v <= 2'h0;
            base_clock_out <= 1'b0;
        end
        else
        begin
            case (sel_state)
                pcg_pkg::SEL_RUN:
                begin
                    if (src_vco != target_vco)
                    begin
                        sel_state <= pcg_pkg::SEL_HOLD;
                        hold_x <= 2'h0;
                        hold_v <= 2'h0;
                    end
                    else if (src_vco ? vco_tick : xtal_tick)
                        base_clock_out <= !base_clock_out;
                end
                pcg_pkg::SEL_HOLD:
                begin
                    // output frozen; a stopped vco does not stall the wait
                    if (xtal_tick && hold_x != pcg_pkg::HOLD_EDGES)
                        hold_x <= hold_x + 2'h1;
                    if (vco_tick && hold_v != pcg_pkg::HOLD_EDGES)
                        hold_v <= hold_v + 2'h1;
                    if (hold_x == pcg_pkg::HOLD_EDGES
                        && (hold_v == pcg_pkg::HOLD_EDGES || !pll_run))
                    begin
                        src_vco <= target_vco;
                        sel_state <= pcg_pkg::SEL_RUN;
                    end
                end
                default:
                    sel_state <= pcg_pkg::SEL_RUN;
            endcase
        end
    end

    // register read, data valid the cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd && reg_addr == pcg_pkg::ADDR_CTRL)
            reg_rdata <= {ctrl.irq_en, 1'b0, ctrl.pll_on, ctrl.bcs,
                3'h0, src_vco};
        else if (reg_rd && reg_addr == pcg_pkg::ADDR_BW)
            reg_rdata <= {bw.auto_bw, lock, bw.track, 5'h00};
        else if (reg_rd && reg_addr == pcg_pkg::ADDR_PROG)
            reg_rdata <= prog;
        else
            reg_rdata <= 8'h00;
    end
endmodule

//--- pcg_pkg.sv
package pcg_pkg;

    // register offsets on the plain register port
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_BW = 4'h1;
    localparam logic [3:0] ADDR_PROG = 4'h2;

    // control register fields
    localparam int CTRL_IRQ_EN_BIT = 7;
    localparam int CTRL_PLL_ON_BIT = 5;
    localparam int CTRL_BCS_BIT = 4;
    localparam int CTRL_SRC_BIT = 0;

    // bandwidth register fields
    localparam int BW_AUTO_BIT = 7;
    localparam int BW_LOCK_BIT = 6;
    localparam int BW_TRACK_BIT = 5;

    // programming register fields: feedback factor high, range factor low
    localparam int PROG_N_LSB = 4;
    localparam int PROG_L_LSB = 0;

    // values after reset
    localparam logic [7:0] PROG_RESET = 8'h00;

    // timing: system clock and nominal vco base
    localparam longint CLK_HZ = 10000000;
    localparam longint NOM_FREQ_HZ = 4915200;
    // the vco model runs this many times slower than the real one
    localparam longint MODEL_SCALE = 64;
    localparam int NCO_BITS = 16;
    localparam logic [15:0] VCO_NOM_INC = 16'((NOM_FREQ_HZ * 65536)
        / (CLK_HZ * MODEL_SCALE));

    // loop filter gains per correction cycle
    localparam logic [15:0] PULL_GAIN = 16'h0008;
    localparam logic [15:0] TRK_GAIN = 16'h0001;

    // lock detector: tolerances in feedback edges per window
    localparam logic [7:0] TRK_TOL = 8'h02;
    localparam logic [7:0] UNT_TOL = 8'h04;
    localparam logic [7:0] LOCK_TOL = 8'h01;
    localparam logic [7:0] UNL_TOL = 8'h03;

    // edges of each clock the selector waits before a switch-over
    localparam logic [1:0] HOLD_EDGES = 2'h3;

    typedef struct packed {
        logic irq_en;
        logic pll_on;
        logic bcs;
    } pcg_ctrl_t;

    typedef struct packed {
        logic auto_bw;
        logic track;
    } pcg_bw_t;

    typedef enum logic [0:0] {
        SEL_RUN = 1'b0,
        SEL_HOLD = 1'b1
    } pcg_sel_state_t;

endpackage

//--- pcg_mod_div.sv
`timescale 1ns/1ns
// modulo divider: one output pulse per factor input pulses
module pcg_mod_div #(
    parameter int WIDTH = 4
)(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tick_in,
    input wire logic [WIDTH-1:0] factor,
    output logic tick_out
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] limit;

    // a factor of zero counts as one
    assign limit = (factor == '0) ? WIDTH'(1) : factor;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            count <= '0;
            tick_out <= 1'b0;
        end
        else
        begin
            tick_out <= 1'b0;
            if (tick_in)
            begin
                if (count >= limit - WIDTH'(1))
                begin
                    count <= '0;
                    tick_out <= 1'b1;
                end
                else
                begin
                    count <= count + WIDTH'(1);
                end
            end
        end
    end
endmodule

//--- pcg_core_assertions.sv
`timescale 1ns/1ns
module pcg_chk #(
    parameter int LOCK_WINDOW = 16
)(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic oscillator_enable_from_sysint,
    input wire logic crystal_amp_output,
    input wire logic crystal_clock,
    input wire logic pll_reference_clock,
    input wire logic base_clock_out,
    input wire logic [15:0] filter_cap_node,
    input wire logic lock_change_req,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    logic xtal_only;
    logic auto_bw;

    // shadows of software requests; a refused vco select still turns off chk_base_xtal
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            xtal_only <= 1'b1;
        else if (reg_wr && reg_addr == pcg_pkg::ADDR_CTRL
                 && reg_wdata[pcg_pkg::CTRL_BCS_BIT])
            xtal_only <= 1'b0;
    end

    // bandwidth mode shadow, never refused
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            auto_bw <= 1'b0;
        else if (reg_wr && reg_addr == pcg_pkg::ADDR_BW)
            auto_bw <= reg_wdata[pcg_pkg::BW_AUTO_BIT];
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_osc_off_out: assert property (
        !oscillator_enable_from_sysint && $past(!oscillator_enable_from_sysint)
        |-> !crystal_clock && !crystal_amp_output)
        else $error("crystal outputs active while oscillator disabled");
    chk_ref_copy: assert property (
        pll_reference_clock == $past(crystal_clock))
        else $error("reference clock is not the delayed crystal clock");
    chk_reset_outs: assert property (
        $past(rst) |-> !base_clock_out && filter_cap_node == 16'h0000)
        else $error("outputs not cleared after reset");
    chk_lock_pulse: assert property (
        lock_change_req |=> !lock_change_req)
        else $error("lock change request longer than one cycle");
    chk_base_xtal: assert property (
        xtal_only |-> ($past(base_clock_out) != $past(base_clock_out, 2))
            == $rose(crystal_clock))
        else $error("base clock not halving the crystal clock");
    chk_lock_manual: assert property (
        !auto_bw [*3] |-> !lock_change_req)
        else $error("lock change request in manual mode");
    chk_bw_manual: assert property (
        reg_rd && reg_addr == pcg_pkg::ADDR_BW && !auto_bw && $past(!auto_bw)
        |=> !reg_rdata[pcg_pkg::BW_LOCK_BIT])
        else $error("lock bit set in manual mode");
    chk_rdata_once: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data without a read");
    chk_unmapped_rd: assert property (
        reg_rd && reg_addr > pcg_pkg::ADDR_PROG |=> reg_rdata == 8'h00)
        else $error("unmapped address read not zero");

    cov_lock: cover property (lock_change_req);
    cov_vco_base: cover property (!xtal_only && $changed(base_clock_out));
    cov_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule

bind pcg_core pcg_chk #(.LOCK_WINDOW(LOCK_WINDOW)) chk_u (
    .clk_sys(clk_sys), .rst(rst),
    .oscillator_enable_from_sysint(oscillator_enable_from_sysint),
    .crystal_amp_output(crystal_amp_output), .crystal_clock(crystal_clock),
    .pll_reference_clock(pll_reference_clock),
    .base_clock_out(base_clock_out), .filter_cap_node(filter_cap_node),
    .lock_change_req(lock_change_req), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

//--- pcg_sysint_model.sv
`timescale 1ns/1ns
// system side: enables the oscillator, models the crystal, counts base edges
module pcg_sysint_model #(
    parameter int HALF = 16
)(
    input wire logic clk_sys,
    input wire logic osc_req,
    input wire logic base_clock_out,
    output logic oscillator_enable_from_sysint,
    output logic crystal_amp_input,
    output logic [15:0] base_edges
);
    int cnt = 0;
    logic last_base = 1'b0;

    initial
    begin
        oscillator_enable_from_sysint = 1'b0;
        crystal_amp_input = 1'b0;
        base_edges = 16'h0000;
    end

    // a crystal only swings while its amplifier is enabled
    always @(posedge clk_sys)
    begin
        oscillator_enable_from_sysint <= osc_req;
        if (!oscillator_enable_from_sysint)
        begin
            cnt <= 0;
            crystal_amp_input <= 1'b0;
        end
        else if (cnt == HALF - 1)
        begin
            cnt <= 0;
            crystal_amp_input <= ~crystal_amp_input;
        end
        else
            cnt <= cnt + 1;
    end

    // every base edge is a system clock phase
    always @(posedge clk_sys)
    begin
        last_base <= base_clock_out;
        if (base_clock_out != last_base)
            base_edges <= base_edges + 16'h0001;
    end
endmodule

//--- pll_clock_generator_core_tb_top.sv
`timescale 1ns/1ns
module pll_clock_generator_core_tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic osc_req = 1'b0;
    logic osc_en, xpin, crystal_amp_output, crystal_clock;
    logic pll_reference_clock, base_clock_out, lock_change_req;
    logic [15:0] filter_cap_node, base_edges;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, rv;
    logic px = 1'b0;
    logic pr = 1'b0;
    int fail_count = 0;
    int tests_run = 0;
    int xrise = 0;
    int rrise = 0;
    int pulses = 0;

    always #50 clk_sys = ~clk_sys;

    pcg_core #(.LOCK_WINDOW(4)) dut_u (
        .clk_sys(clk_sys), .rst(rst),
        .oscillator_enable_from_sysint(osc_en), .crystal_amp_input(xpin),
        .crystal_amp_output(crystal_amp_output), .crystal_clock(crystal_clock),
        .pll_reference_clock(pll_reference_clock),
        .base_clock_out(base_clock_out), .filter_cap_node(filter_cap_node),
        .lock_change_req(lock_change_req), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    pcg_sysint_model #(.HALF(16)) sys_u (
        .clk_sys(clk_sys), .osc_req(osc_req), .base_clock_out(base_clock_out),
        .oscillator_enable_from_sysint(osc_en), .crystal_amp_input(xpin),
        .base_edges(base_edges));

    // edge counters, sampled values from before each edge
    always @(posedge clk_sys)
    begin
        if (crystal_clock && !px) xrise++;
        if (pll_reference_clock && !pr) rrise++;
        if (lock_change_req) pulses++;
        px = crystal_clock;
        pr = pll_reference_clock;
    end

    task automatic end_sim();
        if (fail_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(logic [3:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask

    task automatic rdchk(logic [3:0] a, logic [7:0] exp, string what);
        rd(a);
        check(what, {8'h00, exp}, {8'h00, rv});
    endtask

    // bounded poll of one register bit; running out ends the run
    task automatic poll(logic [3:0] a, int b, logic v, string what);
        int i;
        for (i = 0; i < 5000; i++)
        begin
            rd(a);
            if (rv[b] === v) break;
        end
        check(what, {15'h0, v}, {15'h0, rv[b]});
        if (i == 5000) end_sim();
    endtask

    task automatic t_reset();
        rdchk(pcg_pkg::ADDR_CTRL, 8'h00, "ctrl reset");
        rdchk(pcg_pkg::ADDR_BW, 8'h00, "bw reset");
        rdchk(pcg_pkg::ADDR_PROG, pcg_pkg::PROG_RESET, "prog reset");
        wr(4'h7, 8'hff);
        rdchk(4'h7, 8'h00, "unmapped");
        wr(pcg_pkg::ADDR_PROG, 8'h31);
        rdchk(pcg_pkg::ADDR_PROG, 8'h31, "prog rw");
        wr(pcg_pkg::ADDR_PROG, 8'h00);
    endtask

    task automatic t_xtal();
        logic [15:0] b0;
        logic [1:0] outs;
        b0 = base_edges;
        xrise = 0;
        rrise = 0;
        osc_req <= 1'b1;
        repeat (400) @(posedge clk_sys);
        osc_req <= 1'b0;
        repeat (20) @(posedge clk_sys);
        check("xtal runs", 16'h0001, 16'(xrise > 8));
        check("ref rises", 16'(xrise), 16'(rrise));
        check("base halves", 16'(xrise), base_edges - b0);
        outs = {crystal_clock, crystal_amp_output};
        check("xtal idle", 16'h0, {14'h0, outs});
    endtask

    task automatic t_refuse();
        wr(pcg_pkg::ADDR_CTRL, 8'h10);
        rdchk(pcg_pkg::ADDR_CTRL, 8'h00, "vco bar");
        wr(pcg_pkg::ADDR_CTRL, 8'h30);
        rdchk(pcg_pkg::ADDR_CTRL, 8'h00, "joint change");
    endtask

    task automatic t_pll();
        logic [15:0] b0;
        logic [15:0] ctr;
        int x0;
        int p0;
        ctr = 16'(8 * pcg_pkg::VCO_NOM_INC);
        wr(pcg_pkg::ADDR_PROG, 8'h28);
        repeat (2) @(posedge clk_sys);
        check("centre", ctr, filter_cap_node);
        wr(pcg_pkg::ADDR_BW, 8'h80);
        osc_req <= 1'b1;
        p0 = pulses;
        wr(pcg_pkg::ADDR_CTRL, 8'ha0);
        poll(pcg_pkg::ADDR_BW, pcg_pkg::BW_TRACK_BIT, 1'b1, "track");
        poll(pcg_pkg::ADDR_BW, pcg_pkg::BW_LOCK_BIT, 1'b1, "lock");
        check("lock irq", 16'h0001, 16'(pulses > p0));
        wr(pcg_pkg::ADDR_CTRL, 8'hb0);
        // switch-over freezes the base clock for several crystal edges
        repeat (2) @(posedge clk_sys);
        b0 = base_edges;
        repeat (40) @(posedge clk_sys);
        check("hold", 16'h0, base_edges - b0);
        poll(pcg_pkg::ADDR_CTRL, pcg_pkg::CTRL_SRC_BIT, 1'b1, "vco");
        b0 = base_edges;
        x0 = xrise;
        repeat (640) @(posedge clk_sys);
        x0 = xrise - x0;
        check("vco x2", 16'h1, 16'((base_edges - b0) > x0 + x0 / 2));
        wr(pcg_pkg::ADDR_CTRL, 8'h90);
        rdchk(pcg_pkg::ADDR_CTRL, 8'hb1, "off barred");
        wr(pcg_pkg::ADDR_BW, 8'h20);
        rdchk(pcg_pkg::ADDR_BW, 8'h20, "manual track");
        wr(pcg_pkg::ADDR_BW, 8'h00);
        rdchk(pcg_pkg::ADDR_BW, 8'h00, "manual pull");
        // second write proves the bit is writable, not left over from auto
        wr(pcg_pkg::ADDR_BW, 8'h20);
        rdchk(pcg_pkg::ADDR_BW, 8'h20, "manual set");
        wr(pcg_pkg::ADDR_PROG, 8'h20);
        poll(pcg_pkg::ADDR_CTRL, pcg_pkg::CTRL_SRC_BIT, 1'b0, "osc");
        check("bcs off", 16'h0, {15'h0, rv[pcg_pkg::CTRL_BCS_BIT]});
    endtask

    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_xtal();
        t_refuse();
        t_pll();
        end_sim();
    end
endmodule
